// [logic/ppae_pkg.sv]
// ppae_pkg: register map, attribute codes, values and timing counts
// assumes a byte-wide register port synchronous to core_clk
// How it works
// R01: host loads value at attr_value_low/attr_value_high and code at attr_code_low/attr_code_high first.
// R02: writing one to bit 0 of attr_trigger launches the held command.
// R03: accepted command sets status flag bit 7 of attr_status_flag.
// R04: busy bit 0 of attr_busy high while a command executes.
// R05: writing one to flag bit clears it; host clears after each command.
// R06: code 0x02 sets pattern in bits 2:0, high bits load tx/rx.
// R07: value bits 4, 5, 7 request reseed, autoseed, stop on error.
// R08: code 0x02 values 0x3ff, 0x1ff, 0x2ff disable both, tx, rx.
// R09: prbs command returns 0x02 on success, 0x00 when background busy.
// R10: code 0x01 value 0x07 enables transmitter and receiver.
// R11: host waits for tx and rx ready before enabling comparator.
// R12: code 0x03 value 0x0203 enables the receive data comparator.
// R13: 32-bit hard error counter, reset by code 0x17 value zero.
// R14: code 0x18 value 0x03 selects count; next two 0x1a read halves.
// R15: counter does not accumulate while continuous adaptation runs.
// R16: code 0x001b injects tx errors for value bits.
// R17: code 0x0a value 0x01 starts initial adaptation.
// R18: code 0x0126 value 0x0b00 returns initial adaptation status bit 0.
// R19: code 0x0a value 0x06 starts continuous adaptation.
// R20: code 0x0a value 0x03 also enables continuous adaptation.
// R21: one command at a time; writes ignored while busy; a flag clear write to attr_status_flag still acts while busy.
// R22: error counter saturates at its maximum.
package ppae_pkg;
  localparam logic [7:0]  ADDR_VAL_LO  = 8'h84;
  localparam logic [7:0]  ADDR_VAL_HI  = 8'h85;
  localparam logic [7:0]  ADDR_CODE_LO = 8'h86;
  localparam logic [7:0]  ADDR_CODE_HI = 8'h87;
  localparam logic [7:0]  ADDR_RET_LO  = 8'h88;
  localparam logic [7:0]  ADDR_RET_HI  = 8'h89;
  localparam logic [7:0]  ADDR_FLAG    = 8'h8a;
  localparam logic [7:0]  ADDR_BUSY    = 8'h8b;
  localparam logic [7:0]  ADDR_TRIG    = 8'h90;
  localparam int          FLAG_BIT     = 7;
  localparam int          BUSY_BIT     = 0;
  localparam int          TRIG_BIT     = 0;
  localparam logic [15:0] CODE_CHAN    = 16'h0001;
  localparam logic [15:0] CODE_PRBS    = 16'h0002;
  localparam logic [15:0] CODE_CMP     = 16'h0003;
  localparam logic [15:0] CODE_ADAPT   = 16'h000a;
  localparam logic [15:0] CODE_ERR_RST = 16'h0017;
  localparam logic [15:0] CODE_SEL     = 16'h0018;
  localparam logic [15:0] CODE_RD      = 16'h001a;
  localparam logic [15:0] CODE_INJ     = 16'h001b;
  localparam logic [15:0] CODE_STAT    = 16'h0126;
  localparam logic [15:0] VAL_CHAN_ON  = 16'h0007;
  localparam logic [15:0] VAL_CMP_ON   = 16'h0203;
  localparam logic [15:0] VAL_DIS_BOTH = 16'h03ff;
  localparam logic [15:0] VAL_DIS_TX   = 16'h01ff;
  localparam logic [15:0] VAL_DIS_RX   = 16'h02ff;
  localparam logic [15:0] VAL_SEL_ERR  = 16'h0003;
  localparam logic [15:0] VAL_AD_INIT  = 16'h0001;
  localparam logic [15:0] VAL_AD_CONT  = 16'h0006;
  localparam logic [15:0] VAL_AD_CONT2 = 16'h0003;
  localparam logic [15:0] VAL_AD_STOP  = 16'h0000;
  localparam logic [15:0] VAL_STAT_INI = 16'h0b00;
  localparam logic [15:0] RET_PRBS_OK  = 16'h0002;
  localparam logic [15:0] RET_FAIL     = 16'h0000;
  localparam int          PAT_LSB      = 0;
  localparam int          RESEED_BIT   = 4;
  localparam int          AUTOSEED_BIT = 5;
  localparam int          STOPERR_BIT  = 7;
  localparam int          LOAD_TX_BIT  = 8;
  localparam int          LOAD_RX_BIT  = 9;
  localparam int          EXEC_NS      = 40;
  localparam int          CLK_NS       = 10;
  localparam logic [3:0]  EXEC_CYC     = 4'((EXEC_NS + CLK_NS - 1) / CLK_NS);
  localparam int          INIT_AD_NS   = 500;
  localparam logic [7:0]  INIT_AD_CYC  = 8'(INIT_AD_NS / CLK_NS);
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} ppae_state_t;
endpackage

// [logic/ppae_err_counter.sv]
// ppae_err_counter: saturating 32-bit hard error counter
// assumes err_pulse is one cycle per detected bit error
module ppae_err_counter (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        clear,
  input  wire logic        count_en,
  input  wire logic        err_pulse,
  output logic [31:0]      count
);
  import ppae_pkg::*;
  typedef struct packed {logic [31:0] cnt;} ppae_cnt_t;
  ppae_cnt_t s_reg;
  ppae_cnt_t s_next;
  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.cnt = 32'h0;                                  // [R13]
    end else if (count_en && err_pulse && s_reg.cnt != 32'hffffffff) begin
      s_next.cnt = s_reg.cnt + 32'h1;                      // [R22]
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign count = s_reg.cnt;
  property p_sat;
    @(posedge core_clk) disable iff (srst)
      (s_reg.cnt == 32'hffffffff && !clear) |=> s_reg.cnt == 32'hffffffff;
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped"); // [R22]
  property p_clr;
    @(posedge core_clk) disable iff (srst) clear |=> s_reg.cnt == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("counter not cleared"); // [R13]
  property p_hold;
    @(posedge core_clk) disable iff (srst)
      (!count_en && !clear) |=> $stable(s_reg.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("counted while off"); // [R15]
endmodule

// [logic/ppae_engine.sv]
// ppae_engine: pma attribute command engine with byte register port
// assumes host accesses are single-cycle strobes on core_clk
module ppae_engine (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        bg_busy,
  input  wire logic        rx_bit_err,
  output logic             tx_enable,
  output logic             rx_enable,
  output logic             gen_tx_on,
  output logic             chk_rx_on,
  output logic [2:0]       gen_pattern,
  output logic [2:0]       chk_pattern,
  output logic             gen_reseed,
  output logic             gen_autoseed,
  output logic             chk_reseed,
  output logic             chk_stop_on_err,
  output logic             cmp_on,
  output logic             tx_err_inject,
  output logic             adapt_init_run,
  output logic             adapt_cont_run
);
  import ppae_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    ppae_state_t st;
    logic [15:0] val;
    logic [15:0] code;
    logic [15:0] ret;
    logic        flag;
    logic [3:0]  exec_cnt;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        tx_en;
    logic        rx_en;
    logic        gen_on;
    logic        chk_on;
    logic [2:0]  gen_pat;
    logic [2:0]  chk_pat;
    logic        gen_rs;
    logic        gen_as;
    logic        chk_rs;
    logic        chk_stop;
    logic        cmp;
    logic        sel_err;
    logic        rd_half;
    logic [15:0] inj_cnt;
    logic        inj;
    logic        ad_init;
    logic [7:0]  ad_cnt;
    logic        ad_cont;
  } ppae_state_s_t;

  ppae_state_s_t s_reg;
  ppae_state_s_t s_next;
  logic [31:0]   err_count;
  logic          err_clear;
  logic          launch;
  logic          exec_end;

  assign launch = reg_wr && reg_addr == ADDR_TRIG && reg_wdata[TRIG_BIT]
                  && s_reg.st == ST_IDLE;                  // [R02] [R21]
  assign err_clear = s_reg.st == ST_EXEC && s_reg.exec_cnt == 4'h0
                     && s_reg.code == CODE_ERR_RST && s_reg.val == 16'h0;
  assign exec_end = s_reg.st == ST_EXEC && s_reg.exec_cnt == 4'h0;

  ppae_err_counter u_cnt (
    .core_clk  (core_clk),
    .srst      (srst),
    .clear     (err_clear),
    .count_en  (s_reg.cmp && !s_reg.ad_cont),              // [R15]
    .err_pulse (rx_bit_err),
    .count     (err_count)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    // host value and code writes; ignored while a command runs, flag clear below still acts
    if (reg_wr && s_reg.st == ST_IDLE) begin
      if (reg_addr == ADDR_VAL_LO) begin
        s_next.val[7:0] = reg_wdata;                       // [R01]
      end else if (reg_addr == ADDR_VAL_HI) begin
        s_next.val[15:8] = reg_wdata;                      // [R01]
      end else if (reg_addr == ADDR_CODE_LO) begin
        s_next.code[7:0] = reg_wdata;                      // [R01]
      end else if (reg_addr == ADDR_CODE_HI) begin
        s_next.code[15:8] = reg_wdata;                     // [R01]
      end
    end
    if (reg_wr && reg_addr == ADDR_FLAG && reg_wdata[FLAG_BIT]) begin
      s_next.flag = 1'b0;                                  // [R05]
    end
    if (reg_rd) begin
      s_next.rvalid = 1'b1;
      if (reg_addr == ADDR_VAL_LO) begin
        s_next.rdata = s_reg.val[7:0];
      end else if (reg_addr == ADDR_VAL_HI) begin
        s_next.rdata = s_reg.val[15:8];
      end else if (reg_addr == ADDR_CODE_LO) begin
        s_next.rdata = s_reg.code[7:0];
      end else if (reg_addr == ADDR_CODE_HI) begin
        s_next.rdata = s_reg.code[15:8];
      end else if (reg_addr == ADDR_RET_LO) begin
        s_next.rdata = s_reg.ret[7:0];
      end else if (reg_addr == ADDR_RET_HI) begin
        s_next.rdata = s_reg.ret[15:8];
      end else if (reg_addr == ADDR_FLAG) begin
        s_next.rdata = {s_reg.flag, 7'h0};                 // [R03]
      end else if (reg_addr == ADDR_BUSY) begin
        s_next.rdata = {7'h0, s_reg.st != ST_IDLE};        // [R04]
      end else begin
        s_next.rdata = 8'h00;
      end
    end

    // error injection runs one bit per cycle
    if (s_reg.inj_cnt != 16'h0) begin
      s_next.inj_cnt = s_reg.inj_cnt - 16'h1;
      s_next.inj = 1'b1;                                   // [R16]
    end else begin
      s_next.inj = 1'b0;
    end

    // initial adaptation runs a fixed time
    if (s_reg.ad_init) begin
      if (s_reg.ad_cnt == 8'h0) begin
        s_next.ad_init = 1'b0;
      end else begin
        s_next.ad_cnt = s_reg.ad_cnt - 8'h1;
      end
    end

    case (s_reg.st)
      ST_IDLE: begin
        if (launch) begin
          s_next.st = ST_EXEC;
          s_next.flag = 1'b1;                              // [R03]
          s_next.exec_cnt = EXEC_CYC;
        end
      end
      ST_EXEC: begin
        if (s_reg.exec_cnt != 4'h0) begin
          s_next.exec_cnt = s_reg.exec_cnt - 4'h1;
        end else begin
          s_next.st = ST_DONE;
          s_next.ret = s_reg.val;
          if (s_reg.code == CODE_PRBS) begin
            if (bg_busy) begin
              s_next.ret = RET_FAIL;                       // [R09]
            end else begin
              s_next.ret = RET_PRBS_OK;                    // [R09]
              if (s_reg.val == VAL_DIS_BOTH) begin
                s_next.gen_on = 1'b0;                      // [R08]
                s_next.chk_on = 1'b0;
              end else if (s_reg.val == VAL_DIS_TX) begin
                s_next.gen_on = 1'b0;                      // [R08]
              end else if (s_reg.val == VAL_DIS_RX) begin
                s_next.chk_on = 1'b0;                      // [R08]
              end else begin
                if (s_reg.val[LOAD_TX_BIT]) begin
                  s_next.gen_on = 1'b1;                    // [R06]
                  s_next.gen_pat = s_reg.val[PAT_LSB +: 3];
                  s_next.gen_rs = s_reg.val[RESEED_BIT];   // [R07]
                  s_next.gen_as = s_reg.val[AUTOSEED_BIT];
                end
                if (s_reg.val[LOAD_RX_BIT]) begin
                  s_next.chk_on = 1'b1;                    // [R06]
                  s_next.chk_pat = s_reg.val[PAT_LSB +: 3];
                  s_next.chk_rs = s_reg.val[RESEED_BIT];   // [R07]
                  s_next.chk_stop = s_reg.val[STOPERR_BIT];
                end
              end
            end
          end else if (s_reg.code == CODE_CHAN) begin
            s_next.tx_en = s_reg.val == VAL_CHAN_ON;       // [R10]
            s_next.rx_en = s_reg.val == VAL_CHAN_ON;
          end else if (s_reg.code == CODE_CMP) begin
            s_next.cmp = s_reg.val == VAL_CMP_ON;          // [R12]
          end else if (s_reg.code == CODE_SEL) begin
            s_next.sel_err = s_reg.val == VAL_SEL_ERR;     // [R14]
            s_next.rd_half = 1'b0;
          end else if (s_reg.code == CODE_RD && s_reg.sel_err) begin
            s_next.ret = s_reg.rd_half ? err_count[31:16]
                                       : err_count[15:0];  // [R14]
            s_next.rd_half = !s_reg.rd_half;
          end else if (s_reg.code == CODE_INJ) begin
            s_next.inj_cnt = s_reg.val;                    // [R16]
          end else if (s_reg.code == CODE_ADAPT) begin
            if (s_reg.val == VAL_AD_INIT) begin
              s_next.ad_init = 1'b1;                       // [R17]
              s_next.ad_cnt = INIT_AD_CYC;
            end else if (s_reg.val == VAL_AD_CONT
                         || s_reg.val == VAL_AD_CONT2) begin
              s_next.ad_cont = 1'b1;                       // [R19] [R20]
            end else if (s_reg.val == VAL_AD_STOP) begin
              s_next.ad_cont = 1'b0;
            end
          end else if (s_reg.code == CODE_STAT
                       && s_reg.val == VAL_STAT_INI) begin
            s_next.ret = {15'h0, s_reg.ad_init};           // [R18]
          end
        end
      end
      ST_DONE: begin
        s_next.st = ST_IDLE;                               // [R04]
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata       = s_reg.rdata;
  assign reg_rvalid      = s_reg.rvalid;
  assign tx_enable       = s_reg.tx_en;
  assign rx_enable       = s_reg.rx_en;
  assign gen_tx_on       = s_reg.gen_on;
  assign chk_rx_on       = s_reg.chk_on;
  assign gen_pattern     = s_reg.gen_pat;
  assign chk_pattern     = s_reg.chk_pat;
  assign gen_reseed      = s_reg.gen_rs;
  assign gen_autoseed    = s_reg.gen_as;
  assign chk_reseed      = s_reg.chk_rs;
  assign chk_stop_on_err = s_reg.chk_stop;
  assign cmp_on          = s_reg.cmp;
  assign tx_err_inject   = s_reg.inj;
  assign adapt_init_run  = s_reg.ad_init;
  assign adapt_cont_run  = s_reg.ad_cont;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_launch_flag;
    @(posedge core_clk) disable iff (srst)
      launch |=> s_reg.flag && s_reg.st == ST_EXEC;
  endproperty
  a_launch_flag: assert property (p_launch_flag) // [R03]
    else $error("launch did not set flag");
  property p_busy_len;
    @(posedge core_clk) disable iff (srst)
      launch |=> (s_reg.st == ST_EXEC) [*5] ##1 s_reg.st == ST_DONE
                 ##1 s_reg.st == ST_IDLE;
  endproperty
  a_busy_len: assert property (p_busy_len) // [R04]
    else $error("busy length wrong");
  property p_flag_clr;
    @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == ADDR_FLAG && reg_wdata[FLAG_BIT] && !launch)
      |=> !s_reg.flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) // [R05]
    else $error("flag not cleared");
  property p_no_write_busy;
    @(posedge core_clk) disable iff (srst)
      (s_reg.st != ST_IDLE) |=> $stable(s_reg.val) && $stable(s_reg.code);
  endproperty
  a_no_write_busy: assert property (p_no_write_busy) // [R21]
    else $error("command changed while busy");
  property p_prbs_ret;
    @(posedge core_clk) disable iff (srst)
      (s_reg.st == ST_EXEC && s_reg.exec_cnt == 4'h0
       && s_reg.code == CODE_PRBS)
      |=> s_reg.ret == ($past(bg_busy) ? RET_FAIL : RET_PRBS_OK);
  endproperty
  a_prbs_ret: assert property (p_prbs_ret) // [R09]
    else $error("bad prbs return");
  property p_chan_on;
    @(posedge core_clk) disable iff (srst)
      (s_reg.st == ST_EXEC && s_reg.exec_cnt == 4'h0
       && s_reg.code == CODE_CHAN && s_reg.val == VAL_CHAN_ON)
      |=> tx_enable && rx_enable;
  endproperty
  a_chan_on: assert property (p_chan_on) // [R10]
    else $error("channel not enabled");
  property p_inj;
    @(posedge core_clk) disable iff (srst)
      (s_reg.st == ST_EXEC && s_reg.exec_cnt == 4'h0
       && s_reg.code == CODE_INJ && s_reg.val == 16'h0001)
      |=> ##1 tx_err_inject ##1 !tx_err_inject;
  endproperty
  a_inj: assert property (p_inj) // [R16]
    else $error("single injection wrong");
  property p_dis_both;
    @(posedge core_clk) disable iff (srst)
      (s_reg.st == ST_EXEC && s_reg.exec_cnt == 4'h0 && !bg_busy
       && s_reg.code == CODE_PRBS && s_reg.val == VAL_DIS_BOTH)
      |=> !gen_tx_on && !chk_rx_on;
  endproperty
  a_dis_both: assert property (p_dis_both) // [R08]
    else $error("generators not disabled");
  property p_init_start;
    @(posedge core_clk) disable iff (srst)
      (exec_end && s_reg.code == CODE_ADAPT && s_reg.val == VAL_AD_INIT)
      |=> adapt_init_run;
  endproperty
  a_init_start: assert property (p_init_start) // [R17]
    else $error("initial adaptation not started");
  property p_cont_stop;
    @(posedge core_clk) disable iff (srst)
      (exec_end && s_reg.code == CODE_ADAPT && s_reg.val == VAL_AD_STOP)
      |=> !adapt_cont_run;
  endproperty
  a_cont_stop: assert property (p_cont_stop) // [R19]
    else $error("continuous adaptation not stopped");
  property p_cmp_on;
    @(posedge core_clk) disable iff (srst)
      (exec_end && s_reg.code == CODE_CMP && s_reg.val == VAL_CMP_ON)
      |=> cmp_on;
  endproperty
  a_cmp_on: assert property (p_cmp_on) // [R12]
    else $error("comparator not enabled");
  property p_rd_low;
    @(posedge core_clk) disable iff (srst)
      (exec_end && s_reg.code == CODE_RD && s_reg.sel_err && !s_reg.rd_half)
      |=> s_reg.rd_half
          && {16'h0, s_reg.ret} == ($past(err_count) & 32'hffff);
  endproperty
  a_rd_low: assert property (p_rd_low) // [R14]
    else $error("low counter half not returned");
  property p_busy_rd;
    @(posedge core_clk) disable iff (srst)
      (reg_rd && reg_addr == ADDR_BUSY && s_reg.st != ST_IDLE)
      |=> reg_rvalid && reg_rdata[BUSY_BIT];
  endproperty
  a_busy_rd: assert property (p_busy_rd) // [R04]
    else $error("busy bit not reported");
endmodule

// [bench/ppae_host_model.sv]
// ppae_host_model: host controller on the byte register port
// assumes single-cycle strobes and a registered read answer
module ppae_host_model (
  input  wire logic       core_clk,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic            hang
);
  timeunit 1ns;
  timeprecision 1ps;
  import ppae_pkg::*;

  // expected read notes, {mask, data}
  logic [15:0] exp_q[$];

  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
    hang      = 1'b0;
  end

  // released lines show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e, output logic [7:0] d);
    int n;
    exp_q.push_back({m, e});
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 8) hang <= 1'b1;
    d = reg_rdata;
  endtask

  task automatic cmd(input logic [15:0] code, input logic [15:0] val,
                     input logic [15:0] eret, input logic [15:0] m,
                     output logic [15:0] ret);
    logic [7:0] d;
    int         n;
    wr(ADDR_VAL_LO, val[7:0]);
    wr(ADDR_VAL_HI, val[15:8]);
    wr(ADDR_CODE_LO, code[7:0]);
    wr(ADDR_CODE_HI, code[15:8]);
    wr(ADDR_TRIG, 8'h01);
    rd(ADDR_FLAG, 8'h80, 8'h80, d);
    n = 0;
    d = 8'h01;
    while (d[BUSY_BIT] !== 1'b0 && n < 12) begin
      rd(ADDR_BUSY, 8'h00, 8'h00, d);
      n++;
    end
    if (n == 12) hang <= 1'b1;
    wr(ADDR_FLAG, 8'h80);
    rd(ADDR_FLAG, 8'h80, 8'h00, d);
    rd(ADDR_RET_LO, m[7:0], eret[7:0], d);
    ret[7:0] = d;
    rd(ADDR_RET_HI, m[15:8], eret[15:8], d);
    ret[15:8] = d;
  endtask
endmodule

// [bench/ppae_engine_tb.sv]
// ppae_engine_tb: self-checking bench for the attribute engine
// assumes ppae_host_model drives the register port
module ppae_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppae_pkg::*;

  logic        core_clk, srst, bg_busy, rx_bit_err, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic        reg_rvalid, hang, tx_enable, rx_enable, gen_tx_on;
  logic        chk_rx_on, gen_reseed, gen_autoseed, chk_reseed;
  logic        chk_stop_on_err, cmp_on, tx_err_inject;
  logic        adapt_init_run, adapt_cont_run;
  logic [2:0]  gen_pattern, chk_pattern;
  logic [15:0] r, v, note;
  logic [5:0]  eg, ec;
  logic [1:0]  ld;
  logic [31:0] seed = 32'h46c41b43;
  int          mismatches, tests_run, inj_cnt, n1, nv, k;

  ppae_engine dut_u (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .bg_busy(bg_busy),
    .rx_bit_err(rx_bit_err), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .gen_tx_on(gen_tx_on),
    .chk_rx_on(chk_rx_on), .gen_pattern(gen_pattern),
    .chk_pattern(chk_pattern), .gen_reseed(gen_reseed),
    .gen_autoseed(gen_autoseed), .chk_reseed(chk_reseed),
    .chk_stop_on_err(chk_stop_on_err), .cmp_on(cmp_on),
    .tx_err_inject(tx_err_inject), .adapt_init_run(adapt_init_run),
    .adapt_cont_run(adapt_cont_run));

  ppae_host_model host_u (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .hang(hang));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp,
                         input string s);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [15:0] n);
    tests_run++;
    if ((got & n[15:8]) !== (n[7:0] & n[15:8])) begin
      mismatches++;
      $display("MISMATCH at %0t: read got %h exp %h", $time, got, n[7:0]);
    end
  endtask

  task automatic errs(input int n);
    repeat (n) begin
      @(posedge core_clk);
      rx_bit_err <= 1'b1;
      @(posedge core_clk);
      rx_bit_err <= 1'b0;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (tx_err_inject === 1'b1) inj_cnt++;
    if (reg_rvalid === 1'b1) begin
      if (host_u.exp_q.size() == 0) chk_out(16'h1, 16'h0, "stray read");
      else begin
        note = host_u.exp_q.pop_front();
        chk_rd(reg_rdata, note);
      end
    end
    if (hang === 1'b1) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    bg_busy = 1'b0;
    rx_bit_err = 1'b0;
    eg = 6'h00;
    ec = 6'h00;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    host_u.rd(ADDR_BUSY, 8'h01, 8'h00, d);
    host_u.rd(ADDR_FLAG, 8'h80, 8'h00, d);
    host_u.rd(8'h91, 8'hff, 8'h00, d);
    chk_out(16'({tx_enable, cmp_on, adapt_cont_run}), 16'h0, "reset");
    $display("test reset done");
    host_u.cmd(CODE_CHAN, VAL_CHAN_ON, VAL_CHAN_ON, 16'hffff, r);
    chk_out(16'({tx_enable, rx_enable}), 16'h3, "channel");
    host_u.wr(ADDR_TRIG, 8'h01);
    host_u.wr(ADDR_VAL_LO, 8'h00);
    repeat (8) @(posedge core_clk);
    host_u.rd(ADDR_VAL_LO, 8'hff, 8'h07, d);
    host_u.wr(ADDR_FLAG, 8'h80);
    $display("test channel done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      ld = 2'(i % 3 + 1);
      v = {6'h00, ld, seed[7], 1'b0, seed[5:4], 1'b0, 3'(i)};
      if (ld[0]) eg = {1'b1, v[2:0], v[4], v[5]};
      if (ld[1]) ec = {1'b1, v[2:0], v[4], v[7]};
      host_u.cmd(CODE_PRBS, v, RET_PRBS_OK, 16'hffff, r);
      chk_out(16'({gen_tx_on, gen_pattern, gen_reseed, gen_autoseed}),
              16'(eg), "generator");
      chk_out(16'({chk_rx_on, chk_pattern, chk_reseed, chk_stop_on_err}),
              16'(ec), "checker");
    end
    bg_busy <= 1'b1;
    host_u.cmd(CODE_PRBS, 16'h0300, RET_FAIL, 16'hffff, r);
    chk_out(16'({gen_tx_on, gen_pattern, gen_reseed, gen_autoseed}),
            16'(eg), "refused");
    bg_busy <= 1'b0;
    host_u.cmd(CODE_PRBS, 16'h0300, RET_PRBS_OK, 16'hffff, r);
    host_u.cmd(CODE_PRBS, VAL_DIS_TX, RET_PRBS_OK, 16'hffff, r);
    chk_out(16'({gen_tx_on, chk_rx_on}), 16'h1, "tx off");
    host_u.cmd(CODE_PRBS, VAL_DIS_RX, RET_PRBS_OK, 16'hffff, r);
    chk_out(16'({gen_tx_on, chk_rx_on}), 16'h0, "rx off");
    host_u.cmd(CODE_PRBS, 16'h0300, RET_PRBS_OK, 16'hffff, r);
    host_u.cmd(CODE_PRBS, VAL_DIS_BOTH, RET_PRBS_OK, 16'hffff, r);
    chk_out(16'({gen_tx_on, chk_rx_on}), 16'h0, "both off");
    $display("test prbs done");
    host_u.cmd(CODE_CMP, VAL_CMP_ON, VAL_CMP_ON, 16'hffff, r);
    chk_out(16'(cmp_on), 16'h1, "comparator");
    errs(4);
    host_u.cmd(CODE_ERR_RST, 16'h0000, 16'h0000, 16'hffff, r);
    seed = xs(seed);
    n1 = int'(seed[4:0]) + 1;
    errs(n1);
    host_u.cmd(CODE_ADAPT, VAL_AD_CONT, VAL_AD_CONT, 16'hffff, r);
    chk_out(16'(adapt_cont_run), 16'h1, "continuous");
    errs(7);
    host_u.cmd(CODE_ADAPT, VAL_AD_STOP, VAL_AD_STOP, 16'hffff, r);
    errs(3);
    host_u.cmd(CODE_SEL, VAL_SEL_ERR, VAL_SEL_ERR, 16'hffff, r);
    host_u.cmd(CODE_RD, 16'h0000, 16'(n1 + 3), 16'hffff, r);
    host_u.cmd(CODE_RD, 16'h0000, 16'h0000, 16'hffff, r);
    host_u.cmd(CODE_ADAPT, VAL_AD_CONT2, VAL_AD_CONT2, 16'hffff, r);
    chk_out(16'(adapt_cont_run), 16'h1, "continuous alt");
    host_u.cmd(CODE_ADAPT, VAL_AD_STOP, VAL_AD_STOP, 16'hffff, r);
    $display("test counter done");
    seed = xs(seed);
    for (int j = 0; j < 2; j++) begin
      nv = (j == 0) ? 1 : int'(seed[3:0]) + 2;
      inj_cnt = 0;
      host_u.cmd(CODE_INJ, 16'(nv), 16'(nv), 16'hffff, r);
      repeat (20) @(posedge core_clk);
      chk_out(16'(inj_cnt), 16'(nv), "inject length");
    end
    $display("test inject done");
    host_u.cmd(CODE_ADAPT, VAL_AD_INIT, VAL_AD_INIT, 16'hffff, r);
    chk_out(16'(adapt_init_run), 16'h1, "initial run");
    host_u.cmd(CODE_STAT, VAL_STAT_INI, 16'h0001, 16'h0001, r);
    k = 0;
    while (r[0] !== 1'b0 && k < 10) begin
      host_u.cmd(CODE_STAT, VAL_STAT_INI, 16'h0000, 16'h0000, r);
      k++;
    end
    chk_out(16'({r[0], adapt_init_run}), 16'h0, "initial end");
    $display("test adaptation done");
    end_of_test();
  end
endmodule
